// >>> shared/adcsq_pkg.sv
// Purpose: Shared constants for the converter sequencer control block.
// Assumes: APB slave, 32-bit data, one word per register, byte offsets.
// Notes:
package adcsq_pkg;
	// Bus shape
	localparam int         ADCSQ_AW       = 8;
	localparam int         ADCSQ_DW       = 32;
	// Register byte offsets
	localparam logic [7:0] ADCSQ_OFF_CTRL0 = 8'h00; // converter_control_0
	localparam logic [7:0] ADCSQ_OFF_CTRL1 = 8'h04; // converter_control_1
	localparam logic [7:0] ADCSQ_OFF_PINEN = 8'h08; // analog_pin_enable
	localparam logic [7:0] ADCSQ_OFF_RESL  = 8'h0c;
	localparam logic [7:0] ADCSQ_OFF_RESH  = 8'h10;
	localparam logic [7:0] ADCSQ_OFF_STAT  = 8'h14;
	localparam logic [7:0] ADCSQ_OFF_MASK  = 8'h18;
	// Control 0 field positions
	localparam int         ADCSQ_C0_START = 7;
	localparam int         ADCSQ_C0_BUSY  = 6;
	localparam int         ADCSQ_C0_PD    = 5;
	localparam int         ADCSQ_C0_ALIGN = 4;
	localparam int         ADCSQ_C0_CH    = 0;
	// Control 1 field positions
	localparam int         ADCSQ_C1_BGSEL = 7;
	localparam int         ADCSQ_C1_BGEN  = 6;
	localparam int         ADCSQ_C1_VREF  = 4;
	localparam int         ADCSQ_C1_DIV   = 0;
	// Reset values
	localparam logic [7:0] ADCSQ_RST_PINEN = 8'hff;
	localparam logic       ADCSQ_RST_BUSY  = 1'h1;
	localparam logic       ADCSQ_RST_PD    = 1'h1;
	// Geometry and timing
	localparam int         ADCSQ_NCH        = 8;
	localparam int         ADCSQ_RES_W      = 12;
	localparam int         ADCSQ_CONV_TICKS = 16;
	localparam int         ADCSQ_SAMP_TICKS = 4;
	localparam logic [2:0] ADCSQ_DIV_TOP    = 3'h6; // divide by 64; code 7 acts alike
endpackage : adcsq_pkg

// >>> logic/adcsq_clkdiv.sv
// Purpose: Converter clock enable, system clock divided by two to the select.
// Assumes: Select may change at any time; the count restarts cleanly.
// Notes: The undefined top code is clamped to the largest divisor.
`timescale 1ns/1ps
module adcsq_clkdiv (
	// Clock and reset
	input  wire logic       i_clk,
	input  wire logic       i_rst_b,
	// Control
	input  wire logic [2:0] i_sel,
	input  wire logic       i_run,
	// Enable pulse
	output logic            o_tick
);
	import adcsq_pkg::*;

	logic [5:0] cnt_q;
	logic [2:0] sel_c;
	logic [5:0] lim;
	logic       wrap;

	// Clamp undefined code, then limit is divisor minus one
	assign sel_c = (i_sel > ADCSQ_DIV_TOP) ? ADCSQ_DIV_TOP : i_sel;
	assign lim   = 6'((7'h01 << sel_c) - 7'h01);
	// Compare with >= so a smaller divisor never waits a full wrap
	assign wrap  = cnt_q >= lim;

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			cnt_q  <= 6'h00;
			o_tick <= 1'h0;
		end else begin
			cnt_q  <= (wrap || !i_run) ? 6'h00 : cnt_q + 6'h01;
			o_tick <= wrap && i_run;
		end
	end

	AST_DIV2_SPACING : assert property (@(posedge i_clk) disable iff (!i_rst_b)
		(o_tick && i_run && i_sel == 3'h1 && $past(i_sel) == 3'h1) |=>
		(!o_tick || !i_run || i_sel != 3'h1))
		else $error("Divide-by-two enable pulses too close");
endmodule : adcsq_clkdiv

// >>> logic/adcsq_sar.sv
// Purpose: Successive approximation step engine, one step per converter tick.
// Assumes: Comparator high means input above the trial code.
// Notes: First SAMP ticks sample, the remaining ticks decide one bit each.
`timescale 1ns/1ps
module adcsq_sar #(
	parameter int W      = 12,
	parameter int NTICK  = 16,
	parameter int NSAMP  = 4
) (
	// Clock and reset
	input  wire logic         i_clk,
	input  wire logic         i_rst_b,
	// Control
	input  wire logic         i_clr,
	input  wire logic         i_go,
	input  wire logic         i_tick,
	input  wire logic         i_cmp,
	// Results
	output logic [W-1:0]      o_code,
	output logic [W-1:0]      o_result,
	output logic              o_run,
	output logic              o_done
);
	logic [4:0]   cnt_q;
	logic [4:0]   hcnt_q;
	logic         step;
	logic         last;
	logic [W-1:0] bit_now;
	logic [W-1:0] bit_next;
	logic [W-1:0] code_d;

	assign step     = o_run && i_tick;
	assign last     = cnt_q == 5'(NTICK - 1);
	// Bit under trial at this step, and the one to try next
	assign bit_now  = W'(1) << 5'(NTICK - 1 - int'(cnt_q));
	assign bit_next = bit_now >> 1;
	// keep or drop the trial bit
	assign code_d   = (cnt_q == 5'(NSAMP - 1)) ? W'(1) << (W - 1) :
		(cnt_q < 5'(NSAMP)) ? o_code :
		((i_cmp ? o_code : (o_code & ~bit_now)) | bit_next);

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			cnt_q <= 5'h00;
			o_run <= 1'h0;
			o_code <= '0;
			o_done <= 1'h0;
		end else begin
			// An abort or restart in the last step must not report an end
			o_done <= step && last && !i_clr && !i_go;
			if (i_clr || i_go) begin
				cnt_q <= 5'h00;
				o_run <= i_go && !i_clr;
				o_code <= '0;
			end else if (step) begin
				cnt_q <= cnt_q + 5'h01;
				o_run <= !last;
				o_code <= code_d;
			end
		end
	end

	// result lands with the done pulse
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b)
			o_result <= '0;
		else if (step && last && !i_clr && !i_go)
			o_result <= code_d;
	end

	// Ticks seen since start, for the duration check only
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b)
			hcnt_q <= 5'h00;
		else if (i_clr || i_go)
			hcnt_q <= 5'h00;
		else if (step)
			hcnt_q <= hcnt_q + 5'h01;
	end

	AST_SIXTEEN_TICKS : assert property (@(posedge i_clk) disable iff (!i_rst_b)
		o_done |-> hcnt_q == 5'd16)
		else $error("Conversion did not take sixteen converter clocks");
endmodule : adcsq_sar

// >>> logic/adcsq_top.sv
// Purpose: Converter sequencer control: pins, start handshake, busy, interrupt.
// Assumes: APB master holds each request until ready; analog core outside; comparator async.
// Notes: No wait state on any APB access; ready and read data are registered in the setup cycle, so read data comes from a flop.
`timescale 1ns/1ps
module adcsq_top (
	// Clock and reset
	input  wire logic                           I_MCLK,
	input  wire logic                           I_RST_B,
	// APB slave
	input  wire logic                           I_PSEL,
	input  wire logic                           I_PENABLE,
	input  wire logic                           I_PWRITE,
	input  wire logic [adcsq_pkg::ADCSQ_AW-1:0] I_PADDR,
	input  wire logic [adcsq_pkg::ADCSQ_DW-1:0] I_PWDATA,
	output logic      [adcsq_pkg::ADCSQ_DW-1:0] O_PRDATA,
	output logic                                O_PREADY,
	output logic                                O_PSLVERR,
	// Port settings from the I/O block
	input  wire logic [adcsq_pkg::ADCSQ_NCH-1:0] I_PORT_DIR,
	input  wire logic [adcsq_pkg::ADCSQ_NCH-1:0] I_PULL_EN,
	input  wire logic                            I_GLOBAL_IE,
	// Analog core
	input  wire logic                            I_CMP,
	output logic [adcsq_pkg::ADCSQ_RES_W-1:0]    O_DAC_CODE,
	output logic                                 O_ADC_RST,
	output logic                                 O_ADC_PD,
	output logic [adcsq_pkg::ADCSQ_NCH-1:0]      O_CH_CONNECT,
	output logic                                 O_BG_ROUTE,
	output logic                                 O_BG_EN,
	output logic                                 O_VREF_PIN,
	// Effective pin setup
	output logic [adcsq_pkg::ADCSQ_NCH-1:0]      O_PIN_ANALOG,
	output logic [adcsq_pkg::ADCSQ_NCH-1:0]      O_PORT_DIR,
	output logic [adcsq_pkg::ADCSQ_NCH-1:0]      O_PULL_EN,
	// Interrupt
	output logic                                 O_INT_REQ,
	output logic                                 O_IRQ
);
	import adcsq_pkg::*;

	// Software state
	logic             start_q;
	logic             armed_q;
	logic             busy_q;
	logic             pd_q;
	logic             align_q;
	logic [2:0]       ch_q;
	logic             bgsel_q;
	logic             bgen_q;
	logic             vref_q;
	logic [2:0]       div_q;
	logic [7:0]       pinen_q;
	logic [7:0]       pinen_d;
	logic             stat_q;
	logic             mask_q;
	logic             go_q;
	// Comparator synchroniser
	logic             cmp_s1;
	logic             cmp_s2;
	logic             cmp_s3;
	logic             cmp_q;
	// Engine links
	logic             tick;
	logic             sar_run;
	logic             sar_done;
	logic [11:0]      sar_result;
	logic [11:0]      sar_code;
	// Bus decode
	logic             setup;
	logic             access;
	logic             wr;
	logic             rd;
	logic [7:0]       wdat;
	logic             hit;
	logic             aligned;
	logic             wr_c0;
	logic             wr_c1;
	logic             wr_pe;
	logic             wr_mk;
	logic             rd_st;
	logic             new_start;
	logic             start_rise;
	logic             start_fall;
	logic [7:0]       res_l;
	logic [7:0]       res_h;
	logic [7:0]       rd_byte;

	// Access decode; requests are taken at the access edge only
	assign setup   = I_PSEL && !I_PENABLE;
	assign access  = I_PSEL && I_PENABLE && O_PREADY;
	assign wr      = access && I_PWRITE && !O_PSLVERR;
	assign rd      = access && !I_PWRITE && !O_PSLVERR;
	assign wdat    = I_PWDATA[7:0];
	assign aligned = I_PADDR[1:0] == 2'h0;
	assign hit     = aligned && (I_PADDR <= ADCSQ_OFF_MASK);
	assign wr_c0   = wr && I_PADDR == ADCSQ_OFF_CTRL0;
	assign wr_c1   = wr && I_PADDR == ADCSQ_OFF_CTRL1;
	assign wr_pe   = wr && I_PADDR == ADCSQ_OFF_PINEN;
	assign wr_mk   = wr && I_PADDR == ADCSQ_OFF_MASK;
	assign rd_st   = rd && I_PADDR == ADCSQ_OFF_STAT;

	// start edges seen on writes of control 0
	assign new_start  = wdat[ADCSQ_C0_START];
	assign start_rise = wr_c0 && new_start && !start_q;
	assign start_fall = wr_c0 && !new_start && start_q && armed_q;

	assign res_h = align_q ? {4'h0, sar_result[11:8]} : sar_result[11:4];
	assign res_l = align_q ? sar_result[7:0] : {sar_result[3:0], 4'h0};

	// Read mux; unmapped addresses read zero
	assign rd_byte =
		(I_PADDR == ADCSQ_OFF_CTRL0) ? {start_q, busy_q, pd_q, align_q, 1'h0, ch_q} :
		(I_PADDR == ADCSQ_OFF_CTRL1) ? {bgsel_q, bgen_q, 1'h0, vref_q, 1'h0, div_q} :
		(I_PADDR == ADCSQ_OFF_PINEN) ? pinen_q :
		(I_PADDR == ADCSQ_OFF_RESL)  ? res_l :
		(I_PADDR == ADCSQ_OFF_RESH)  ? res_h :
		(I_PADDR == ADCSQ_OFF_STAT)  ? {7'h00, stat_q} :
		(I_PADDR == ADCSQ_OFF_MASK)  ? {7'h00, mask_q} : 8'h00;

	assign pinen_d = wr_pe ? wdat : pinen_q;

	// APB answer: ready one cycle after setup, data latched in setup
	always_ff @(posedge I_MCLK or negedge I_RST_B) begin
		if (!I_RST_B) begin
			O_PREADY  <= 1'h0;
			O_PSLVERR <= 1'h0;
			O_PRDATA  <= 32'h0000_0000;
		end else begin
			O_PREADY  <= setup;
			O_PSLVERR <= setup && !hit;
			if (setup)
				O_PRDATA <= {24'h00_0000, hit ? rd_byte : 8'h00};
		end
	end

	// Configuration registers of control 0 and 1
	always_ff @(posedge I_MCLK or negedge I_RST_B) begin
		if (!I_RST_B) begin
			pd_q    <= ADCSQ_RST_PD;
			align_q <= 1'h0;
			ch_q    <= 3'h0;
			bgsel_q <= 1'h0;
			bgen_q  <= 1'h0;
			vref_q  <= 1'h0;
			div_q   <= 3'h0;
		end else begin
			if (wr_c0) begin
				pd_q    <= wdat[ADCSQ_C0_PD];
				align_q <= wdat[ADCSQ_C0_ALIGN];
				ch_q    <= wdat[ADCSQ_C0_CH +: 3];
			end
			if (wr_c1) begin
				bgsel_q <= wdat[ADCSQ_C1_BGSEL];
				bgen_q  <= wdat[ADCSQ_C1_BGEN];
				vref_q  <= wdat[ADCSQ_C1_VREF];
				div_q   <= wdat[ADCSQ_C1_DIV +: 3];
			end
		end
	end

	// pin enables reset to all analog
	always_ff @(posedge I_MCLK or negedge I_RST_B) begin
		if (!I_RST_B)
			pinen_q <= ADCSQ_RST_PINEN;
		else
			pinen_q <= pinen_d;
	end

	// start bit, arm flag and one-cycle go pulse
	always_ff @(posedge I_MCLK or negedge I_RST_B) begin
		if (!I_RST_B) begin
			start_q <= 1'h0;
			armed_q <= 1'h0;
			go_q    <= 1'h0;
		end else begin
			if (wr_c0)
				start_q <= new_start;
			if (start_rise)
				armed_q <= 1'h1;
			else if (start_fall)
				armed_q <= 1'h0;
			go_q <= start_fall;
		end
	end

	// busy set by start rise, cleared by conversion end
	always_ff @(posedge I_MCLK or negedge I_RST_B) begin
		if (!I_RST_B)
			busy_q <= ADCSQ_RST_BUSY;
		else if (start_rise || start_q)
			busy_q <= 1'h1;
		else if (sar_done)
			busy_q <= 1'h0;
	end

	// sticky request; a new end wins over the read clear
	always_ff @(posedge I_MCLK or negedge I_RST_B) begin
		if (!I_RST_B) begin
			stat_q <= 1'h0;
			mask_q <= 1'h0;
			O_IRQ  <= 1'h0;
		end else begin
			if (sar_done)
				stat_q <= 1'h1;
			else if (rd_st)
				stat_q <= 1'h0;
			if (wr_mk)
				mask_q <= wdat[0];
			O_IRQ <= (sar_done || (stat_q && !rd_st)) && mask_q && I_GLOBAL_IE;
		end
	end
	assign O_INT_REQ = stat_q;

	// Comparator crosses from the analog side; accept when stages 2 and 3 agree
	always_ff @(posedge I_MCLK or negedge I_RST_B) begin
		if (!I_RST_B) begin
			cmp_s1 <= 1'h0;
			cmp_s2 <= 1'h0;
			cmp_s3 <= 1'h0;
			cmp_q  <= 1'h0;
		end else begin
			cmp_s1 <= I_CMP;
			cmp_s2 <= cmp_s1;
			cmp_s3 <= cmp_s2;
			if (cmp_s2 == cmp_s3)
				cmp_q <= cmp_s3;
		end
	end

	// converter clock stops while powered down, so a conversion stalls
	adcsq_clkdiv u_div (
		.i_clk   (I_MCLK),
		.i_rst_b (I_RST_B),
		.i_sel   (div_q),
		.i_run   (!pd_q),
		.o_tick  (tick)
	);

	// step engine; start held high keeps it cleared
	adcsq_sar #(
		.W     (ADCSQ_RES_W),
		.NTICK (ADCSQ_CONV_TICKS),
		.NSAMP (ADCSQ_SAMP_TICKS)
	) u_sar (
		.i_clk    (I_MCLK),
		.i_rst_b  (I_RST_B),
		.i_clr    (start_q),
		.i_go     (go_q),
		.i_tick   (tick),
		.i_cmp    (cmp_q),
		.o_code   (sar_code),
		.o_result (sar_result),
		.o_run    (sar_run),
		.o_done   (sar_done)
	);
	assign O_DAC_CODE = sar_code;
	assign O_ADC_RST  = start_q;

	// Analog routing and pin overrides; power down and pin overrides built from next values so they never lag, routing from the stored fields
	always_ff @(posedge I_MCLK or negedge I_RST_B) begin
		if (!I_RST_B) begin
			O_ADC_PD     <= ADCSQ_RST_PD;
			O_CH_CONNECT <= 8'h00;
			O_BG_ROUTE   <= 1'h0;
			O_BG_EN      <= 1'h0;
			O_VREF_PIN   <= 1'h0;
			O_PIN_ANALOG <= ADCSQ_RST_PINEN;
			O_PORT_DIR   <= ADCSQ_RST_PINEN;
			O_PULL_EN    <= 8'h00;
		end else begin
			O_ADC_PD     <= wr_c0 ? wdat[ADCSQ_C0_PD] : pd_q;
			O_CH_CONNECT <= bgsel_q ? 8'h00 : (8'h01 << ch_q);
			O_BG_ROUTE   <= bgsel_q;
			O_BG_EN      <= bgen_q;
			O_VREF_PIN   <= vref_q;
			O_PIN_ANALOG <= pinen_d;
			O_PORT_DIR   <= I_PORT_DIR | pinen_d;
			O_PULL_EN    <= I_PULL_EN & ~pinen_d;
		end
	end

	AST_PINS_RESET_ANALOG : assert property (@(posedge I_MCLK) disable iff (!I_RST_B)
		(!$past(I_RST_B)) |-> O_PIN_ANALOG == 8'hff)
		else $error("Pins not all analog after reset");

	AST_START_PULSE_RUNS : assert property (@(posedge I_MCLK) disable iff (!I_RST_B)
		start_fall |-> ##2 sar_run)
		else $error("Start pulse did not begin a conversion");

	AST_START_HOLD_RESET : assert property (@(posedge I_MCLK) disable iff (!I_RST_B)
		(start_q && $past(start_q)) |-> (busy_q && O_ADC_RST && !sar_run))
		else $error("Held start did not hold converter in reset");

	AST_BUSY_CLEARS : assert property (@(posedge I_MCLK) disable iff (!I_RST_B)
		(sar_done && !start_q && !start_rise) |=> !busy_q)
		else $error("Busy flag did not clear at conversion end");

	AST_REQ_AT_END : assert property (@(posedge I_MCLK) disable iff (!I_RST_B)
		sar_done |=> (stat_q && (O_IRQ == ($past(mask_q) && $past(I_GLOBAL_IE)))))
		else $error("Request or interrupt wrong at conversion end");

	AST_ANALOG_OVERRIDES : assert property (@(posedge I_MCLK) disable iff (!I_RST_B)
		((O_PORT_DIR & O_PIN_ANALOG) == O_PIN_ANALOG))
		else $error("Analog pin not forced to input");

	AST_PULL_DROPPED : assert property (@(posedge I_MCLK) disable iff (!I_RST_B)
		((O_PULL_EN & O_PIN_ANALOG) == 8'h00))
		else $error("Pull-high left on an analog pin");

	AST_BANDGAP_ISOLATES : assert property (@(posedge I_MCLK) disable iff (!I_RST_B)
		O_BG_ROUTE |-> O_CH_CONNECT == 8'h00)
		else $error("Pin connected while bandgap routed");

	AST_RESULT_FIRST : assert property (@(posedge I_MCLK) disable iff (!I_RST_B)
		$fell(busy_q) |-> ($past(sar_done) && $stable(sar_result)))
		else $error("Busy fell without a settled result");
endmodule : adcsq_top

// >>> test/adcsq_top_test.sv
// Purpose: Self-checking bench for the converter sequencer control block.
// Assumes: APB slave answers in its own time; comparator held constant per conversion.
// Notes: A constant comparator level makes the expected code all ones or all
//        zeros, so the check does not depend on the comparator sync delay.
`timescale 1ns/1ps
module adcsq_top_test;
	import adcsq_pkg::*;

	// Bench limits
	localparam int LIMIT = 20000;

	// Design stimulus, all defined at time zero
	logic        clk       = 1'b0;
	logic        rst_b     = 1'b0;
	logic        psel      = 1'b0;
	logic        penable   = 1'b0;
	logic        pwrite    = 1'b0;
	logic [7:0]  paddr     = 8'h00;
	logic [31:0] pwdata    = 32'h0;
	logic [7:0]  port_dir  = 8'h00;
	logic [7:0]  pull_en   = 8'h00;
	logic        global_ie = 1'b0;
	logic        cmp       = 1'b0;
	// Design outputs
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [11:0] dac_code;
	logic        adc_rst;
	logic        adc_pd;
	logic [7:0]  ch_connect;
	logic        bg_route;
	logic        bg_en;
	logic        vref_pin;
	logic [7:0]  pin_analog;
	logic [7:0]  port_dir_o;
	logic [7:0]  pull_en_o;
	logic        int_req;
	logic        irq;
	// Bookkeeping
	int          err_count = 0;
	int          cmp_count = 0;
	int          cyc       = 0;
	logic [31:0] seed      = 32'd71;

	adcsq_top dut (
		.I_MCLK(clk), .I_RST_B(rst_b), .I_PSEL(psel), .I_PENABLE(penable),
		.I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata),
		.O_PREADY(pready), .O_PSLVERR(pslverr), .I_PORT_DIR(port_dir),
		.I_PULL_EN(pull_en), .I_GLOBAL_IE(global_ie), .I_CMP(cmp),
		.O_DAC_CODE(dac_code), .O_ADC_RST(adc_rst), .O_ADC_PD(adc_pd),
		.O_CH_CONNECT(ch_connect), .O_BG_ROUTE(bg_route), .O_BG_EN(bg_en),
		.O_VREF_PIN(vref_pin), .O_PIN_ANALOG(pin_analog), .O_PORT_DIR(port_dir_o),
		.O_PULL_EN(pull_en_o), .O_INT_REQ(int_req), .O_IRQ(irq)
	);

	// Clock, 4 ns period
	initial begin
		forever #2 clk = ~clk;
	end

	// Hang guard: a stuck handshake must still reach the verdict
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == LIMIT) begin
			err_count++;
			$display("ERROR %0t cycle limit reached", $time);
			summarize();
		end
	end

	// Repeatable pseudo-random source
	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : xs

	// Expected result byte for a code, alignment and byte half
	function automatic logic [31:0] res_byte(input logic [11:0] v, input logic al,
			input logic hi);
		if (al) begin
			return hi ? {28'h0, v[11:8]} : {24'h0, v[7:0]};
		end
		return hi ? {24'h0, v[11:4]} : {24'h0, v[3:0], 4'h0};
	endfunction : res_byte

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		cmp_count++;
		if (got !== exp) begin
			err_count++;
			$display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask : chk

	task automatic chk_rng(input int got, input int lo, input int hi, input string what);
		cmp_count++;
		if (got < lo || got > hi) begin
			err_count++;
			$display("ERROR %0t %s %0d outside %0d..%0d", $time, what, got, lo, hi);
		end
	endtask : chk_rng

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask : tick

	// One APB transfer; request held until pready is seen at an edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
			output logic [31:0] r, output logic e);
		@(posedge clk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1) begin
			@(posedge clk);
		end
		r = prdata;
		e = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic        e;
		apb(1'b1, a, d, r, e);
		chk(e, 1'b0, "write error flag");
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [31:0] r);
		logic e;
		apb(1'b0, a, 32'h0, r, e);
		chk(e, 1'b0, "read error flag");
	endtask : rd

	// Rise, hold, fall of start, then follow the conversion to its end
	task automatic conv(input logic [2:0] dv, input logic al, input logic cv,
			input logic g, input logic stall);
		logic [31:0] r;
		logic [31:0] c0;
		logic [11:0] full;
		int          n;
		int          p;
		p = 1 << ((dv > ADCSQ_DIV_TOP) ? 6 : dv);
		full = cv ? 12'hfff : 12'h000;
		c0 = {27'h0, al, 4'h0};
		n = 0;
		cmp <= cv;
		global_ie <= g;
		// period limit is the analog core's concern; all codes run here
		wr(ADCSQ_OFF_CTRL1, {29'h0, dv});
		wr(ADCSQ_OFF_MASK, 32'h1);
		wr(ADCSQ_OFF_CTRL0, c0 | 32'h80);
		rd(ADCSQ_OFF_CTRL0, r);
		chk(r[6], 1'b1, "busy while start high");
		tick(40);
		chk(adc_rst, 1'b1, "converter held reset");
		chk(int_req, 1'b0, "no end while start high");
		chk(dac_code, 32'h0, "trial code held clear");
		wr(ADCSQ_OFF_CTRL0, c0);
		if (stall) begin
			wr(ADCSQ_OFF_CTRL0, c0 | 32'h20);
			tick(200);
			chk(int_req, 1'b0, "no end while powered down");
			chk(adc_pd, 1'b1, "power down output");
			wr(ADCSQ_OFF_CTRL0, c0);
		end
		while (int_req !== 1'b1 && n < 3000) begin
			@(posedge clk);
			#1;
			n++;
		end
		if (!stall) begin
			// Go, first tick within one period, fifteen periods, done, flag
			chk_rng(n, 15 * p + 3, 16 * p + 2, "conversion length");
		end
		if (!stall && dv == 3'h0) begin
			chk(n, 32'd18, "undivided conversion length");
		end
		rd(ADCSQ_OFF_CTRL0, r);
		chk(r[6], 1'b0, "busy cleared at end");
		chk(dac_code, {20'h0, full}, "final code on converter");
		rd(ADCSQ_OFF_RESL, r);
		chk(r, res_byte(full, al, 1'b0), "result low");
		rd(ADCSQ_OFF_RESH, r);
		chk(r, res_byte(full, al, 1'b1), "result high");
		tick(2);
		chk(irq, g, "interrupt follows enables");
		rd(ADCSQ_OFF_STAT, r);
		chk(r, 32'h1, "end event in status");
		tick(2);
		chk(int_req, 1'b0, "request cleared by read");
		chk(irq, 1'b0, "interrupt dropped");
		$display("TEST conversion div %0d align %0d done", dv, al);
	endtask : conv

	task automatic summarize();
		$display("COUNTS compares %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : summarize

	// Main sequence
	initial begin
		logic [31:0] r;
		logic [31:0] x;
		logic [7:0]  an;
		logic        e;
		tick(3);
		chk(adc_pd, 1'b1, "power down at reset");
		chk(pin_analog, 8'hff, "pins analog at reset");
		chk(port_dir_o, 8'hff, "direction at reset");
		rst_b <= 1'b1;
		rd(ADCSQ_OFF_CTRL0, r);
		chk(r, 32'h60, "control 0 reset");
		rd(ADCSQ_OFF_CTRL1, r);
		chk(r, 32'h0, "control 1 reset");
		rd(ADCSQ_OFF_PINEN, r);
		chk(r, 32'hff, "pin enable reset");
		apb(1'b0, 8'h1c, 32'h0, r, e);
		chk({r[30:0], e}, 32'h1, "unmapped read refused");
		apb(1'b1, 8'h02, 32'hff, r, e);
		chk(e, 1'b1, "unaligned write refused");
		$display("TEST reset done");
		for (int i = 0; i < 6; i++) begin
			x = xs();
			an = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : x[7:0];
			port_dir <= x[15:8];
			pull_en <= x[23:16];
			wr(ADCSQ_OFF_PINEN, {24'h0, an});
			tick(3);
			chk(pin_analog, an, "analog pins");
			chk(port_dir_o, x[15:8] | an, "direction override");
			chk(pull_en_o, x[23:16] & ~an, "pull dropped");
			rd(ADCSQ_OFF_PINEN, r);
			chk(r, {24'h0, an}, "pin enable read back");
		end
		$display("TEST pins done");
		for (int c = 0; c < 8; c++) begin
			wr(ADCSQ_OFF_CTRL0, c);
			tick(3);
			chk(ch_connect, 8'h1 << c, "channel switch");
		end
		chk(adc_pd, 1'b0, "powered on");
		wr(ADCSQ_OFF_CTRL1, 32'hd0);
		tick(3);
		chk({ch_connect, bg_route, bg_en}, 10'h3, "bandgap routed");
		chk(vref_pin, 1'b1, "reference pin taken");
		wr(ADCSQ_OFF_CTRL1, 32'h0);
		tick(3);
		chk(vref_pin, 1'b0, "supply reference");
		$display("TEST routing done");
		for (int d = 0; d < 8; d++) begin
			x = xs();
			conv(d[2:0], d[0], d[2] ^ x[0], d[1] ^ x[1], 1'b0);
		end
		conv(3'h0, 1'b1, 1'b1, 1'b1, 1'b1);
		wr(ADCSQ_OFF_CTRL0, 32'h40);
		tick(40);
		chk(int_req, 1'b0, "fall without rise ignored");
		rd(ADCSQ_OFF_CTRL0, r);
		chk(r, 32'h0, "busy not writable");
		$display("TEST refusals done");
		summarize();
	end
endmodule : adcsq_top_test
